//--- shared/pwr_cfg.svh
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
// register byte addresses
`define ADDR_CPU_CONTROL_STATUS 4'h0
`define ADDR_CORE_STATUS        4'h4
// sleep select field position
`define SEL_LSB 10
`define SEL_MSB 15
// control/status bit 0: global irq enable; bit 1: nonmaskable irq enable
`define GIE_BIT  0
`define NONMASKABLE_IRQ_ENABLE_BIT 1
// field encodings
`define SEL_NONE      6'h00
`define SEL_LIGHT_EN  6'h09
`define SEL_LIGHT_ANY 6'h11
`define SEL_HALT      6'h1A
`define SEL_PLLSTOP   6'h1C
// reset value of control/status register
`define CSR_RESET 32'h0000_0000
// light sleep entry delay in cycles after the write
`define ENTRY_DELAY 4'h8
// pll lock time, typical in us, maximum is 250% of typical
`define LOCK_TYP_US 75
`define LOCK_MAX_PCT 250
`define CLK_MHZ 125
// rounded up so the wait never falls short of the maximum lock time
`define LOCK_CYCLES ((`LOCK_TYP_US * `LOCK_MAX_PCT * `CLK_MHZ + 99) / 100)
`endif

//--- shared/pwr_pkg.sv
package pwr_pkg;
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_ARM     = 3'b001,
    ST_LIGHT   = 3'b011,
    ST_RESUME  = 3'b010,
    ST_HALT    = 3'b110,
    ST_PLLSTOP = 3'b111,
    ST_RELOCK  = 3'b100
  } sleep_state_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic dma_clk_en;
    logic irq_clk_en;
    logic pll_out_en;
    logic pll_in_en;
  } clk_ctrl_t;
  typedef struct packed {
    logic run_isr;
    logic resume;
  } wake_t;
endpackage

//--- src/cpu_power_down_control.sv
`timescale 1ns/100ps
`include "pwr_cfg.svh"
// Function
// - sleep level chosen from bits 10 to 15
// - light sleep takes effect 8-9 cycles later
// - unenabled irq wake resumes without service routine
// - enabled irq wake runs service routine, then resumes
// - service routine needs global and nonmaskable enables
// - deep levels exit only by reset
// - 001001 light sleep enabled wake; 000000 none
// - 010001 light sleep, any irq wakes
// - 011010 clock halt; 011100 pll input stop
// - light sleep gates cpu clock, irq clocked
// - dma keeps running in light sleep
// - clock halt stops pll output clock
// - deep levels drive indicator pin high
// - deep levels retain registers and ram
// - deep levels freeze functional outputs
// - pll input stop stops pll input clock
// - after pll input stop reset, wait relock
// - relock wait covers 250% of 75 us
module cpu_power_down_control #(
  parameter int unsigned LOCK_CYCLES = `LOCK_CYCLES
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic [3:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // interrupt request from the core interrupt logic
  input  wire logic                irq_pending,
  input  wire logic                irq_enabled,
  // power-up flag: high when the reset came from pll input stop
  input  wire logic                pll_cold_start,
  // clock and wake controls
  output pwr_pkg::clk_ctrl_t       clk_ctrl,
  output pwr_pkg::wake_t           wake,
  output logic                     io_freeze,
  output logic                     sleep_indicator_pin,
  output logic                     core_ready
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0]           cpu_control_status;
  pwr_pkg::sleep_state_t state;
  pwr_pkg::sleep_state_t next_state;
  logic [3:0]            entry_cnt;
  logic [31:0]           lock_cnt;
  logic                  aw_held;
  logic                  w_held;
  logic [3:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  relock_needed;

  // decode of the sleep select field
  wire logic [5:0] sleep_select_field =
    cpu_control_status[`SEL_MSB:`SEL_LSB];
  wire logic sel_light_en  = sleep_select_field == `SEL_LIGHT_EN;
  wire logic sel_light_any = sleep_select_field == `SEL_LIGHT_ANY;
  wire logic sel_halt      = sleep_select_field == `SEL_HALT;
  wire logic sel_pllstop   = sleep_select_field == `SEL_PLLSTOP;
  // reserved codes fall through to no power-down
  wire logic sel_light     = sel_light_en | sel_light_any;
  wire logic isr_allowed   = cpu_control_status[`GIE_BIT] &
                             cpu_control_status[`NONMASKABLE_IRQ_ENABLE_BIT];
  wire logic wake_any      = irq_pending;
  wire logic wake_en       = irq_pending & irq_enabled;
  wire logic light_wake    = sel_light_any ? wake_any : wake_en;
  // relock wait only after a reset that ended pll input stop
  wire logic relock_wait   = state == pwr_pkg::ST_RELOCK &&
                             (relock_needed || pll_cold_start);

  // bus write handshake: address and data taken in either order
  wire logic do_write  = aw_held & w_held & ~s_axi_bvalid;
  wire logic csr_hit   = aw_addr == `ADDR_CPU_CONTROL_STATUS;
  wire logic sel_write = do_write & csr_hit;
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;

  // capture write address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= csr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control/status register, kept through deep sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_control_status <= `CSR_RESET;
    end else if (sel_write) begin
      cpu_control_status <= merge_bytes(cpu_control_status, w_data,
                                        w_strb);
    end else if (state == pwr_pkg::ST_RESUME) begin
      cpu_control_status[`SEL_MSB:`SEL_LSB] <= `SEL_NONE;
    end
  end

  // read channel: control word or status
  wire logic [31:0] status_word = {24'h00_0000, core_ready,
    sleep_indicator_pin, io_freeze, clk_ctrl};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      if (s_axi_araddr == `ADDR_CPU_CONTROL_STATUS) begin
        s_axi_rdata <= cpu_control_status;
      end else if (s_axi_araddr == `ADDR_CORE_STATUS) begin
        s_axi_rdata <= status_word;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sleep sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      pwr_pkg::ST_RUN: begin
        if (sel_write) begin
          next_state = pwr_pkg::ST_ARM;
        end
      end
      pwr_pkg::ST_ARM: begin
        if (entry_cnt == `ENTRY_DELAY) begin
          if (sel_light) begin
            next_state = pwr_pkg::ST_LIGHT;
          end else if (sel_halt) begin
            next_state = pwr_pkg::ST_HALT;
          end else if (sel_pllstop) begin
            next_state = pwr_pkg::ST_PLLSTOP;
          end else begin
            next_state = pwr_pkg::ST_RUN;
          end
        end
      end
      pwr_pkg::ST_LIGHT: begin
        if (light_wake) begin
          next_state = pwr_pkg::ST_RESUME;
        end
      end
      pwr_pkg::ST_RESUME: next_state = pwr_pkg::ST_RUN;
      pwr_pkg::ST_HALT: next_state = pwr_pkg::ST_HALT;
      pwr_pkg::ST_PLLSTOP: next_state = pwr_pkg::ST_PLLSTOP;
      pwr_pkg::ST_RELOCK: begin
        if (!relock_wait || lock_cnt == LOCK_CYCLES - 1) begin
          next_state = pwr_pkg::ST_RUN;
        end
      end
      default: next_state = pwr_pkg::ST_RUN;
    endcase
  end

  // state, entry delay and relock counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= pwr_pkg::ST_RELOCK;
      entry_cnt <= 4'h0;
      lock_cnt  <= 32'h0000_0000;
    end else begin
      state     <= next_state;
      entry_cnt <= (state == pwr_pkg::ST_ARM) ? entry_cnt + 4'h1 : 4'h1;
      lock_cnt  <= (state == pwr_pkg::ST_RELOCK) ?
                   lock_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // relock is skipped unless the reset followed pll input stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relock_needed <= 1'b0;
    end else begin
      relock_needed <= pll_cold_start;
    end
  end

  // clock gates and pins
  wire logic in_light = state == pwr_pkg::ST_LIGHT;
  wire logic in_deep  = state == pwr_pkg::ST_HALT ||
                        state == pwr_pkg::ST_PLLSTOP;
  assign clk_ctrl.cpu_clk_en = ~in_light & ~in_deep & ~relock_wait;
  assign clk_ctrl.irq_clk_en = ~in_deep;
  assign clk_ctrl.dma_clk_en = ~in_deep;
  assign clk_ctrl.pll_out_en = ~in_deep;
  assign clk_ctrl.pll_in_en  = state != pwr_pkg::ST_PLLSTOP;
  assign sleep_indicator_pin = in_deep;
  assign io_freeze           = in_deep;
  assign core_ready = state != pwr_pkg::ST_RELOCK || !relock_wait;
  // wake pulse: resume at sleep point, isr only if enabled irq and allowed
  assign wake.resume  = state == pwr_pkg::ST_RESUME;
  assign wake.run_isr = state == pwr_pkg::ST_RESUME &&
                        irq_enabled && isr_allowed;

  // assertions
  sequence s_arm_hold;
    (state == pwr_pkg::ST_ARM)[*8];
  endsequence
  sequence s_arm_leave;
    state != pwr_pkg::ST_ARM;
  endsequence
  property p_entry;
    @(posedge aclk) disable iff (!aresetn)
    (state == pwr_pkg::ST_RUN && sel_write) |=> s_arm_hold ##1 s_arm_leave;
  endproperty
  a_entry: assert property (p_entry) else $error("entry delay wrong");
  property p_deep_pin;
    @(posedge aclk) disable iff (!aresetn)
    in_deep |-> sleep_indicator_pin && io_freeze && !clk_ctrl.pll_out_en;
  endproperty
  a_deep_pin: assert property (p_deep_pin) else $error("deep pins");
  property p_stay;
    @(posedge aclk) disable iff (!aresetn)
    in_deep |=> in_deep;
  endproperty
  a_stay: assert property (p_stay) else $error("deep exit");
  property p_light_gate;
    @(posedge aclk) disable iff (!aresetn)
    in_light |-> !clk_ctrl.cpu_clk_en && clk_ctrl.irq_clk_en &&
                 clk_ctrl.dma_clk_en;
  endproperty
  a_light_gate: assert property (p_light_gate) else $error("gate");
  property p_isr;
    @(posedge aclk) disable iff (!aresetn)
    wake.run_isr |-> isr_allowed && wake.resume;
  endproperty
  a_isr: assert property (p_isr) else $error("isr gating");
  property p_wake_any;
    @(posedge aclk) disable iff (!aresetn)
    (in_light && sel_light_any && irq_pending) |=> wake.resume;
  endproperty
  a_wake_any: assert property (p_wake_any) else $error("wake any");
  property p_wake_en;
    @(posedge aclk) disable iff (!aresetn)
    (in_light && sel_light_en && !irq_enabled) |=> !wake.resume;
  endproperty
  a_wake_en: assert property (p_wake_en) else $error("wake en");
  property p_pllin;
    @(posedge aclk) disable iff (!aresetn)
    (state == pwr_pkg::ST_PLLSTOP) |-> !clk_ctrl.pll_in_en;
  endproperty
  a_pllin: assert property (p_pllin) else $error("pll in");
  property p_relock_gate;
    @(posedge aclk) disable iff (!aresetn)
    relock_wait |-> !core_ready && !clk_ctrl.cpu_clk_en;
  endproperty
  a_relock_gate: assert property (p_relock_gate) else $error("relock");
  property p_relock_len;
    @(posedge aclk) disable iff (!aresetn)
    (relock_wait && lock_cnt < LOCK_CYCLES - 1) |=>
      state == pwr_pkg::ST_RELOCK;
  endproperty
  a_relock_len: assert property (p_relock_len) else $error("lock");
  property p_reserved;
    @(posedge aclk) disable iff (!aresetn)
    (state == pwr_pkg::ST_ARM && entry_cnt == `ENTRY_DELAY &&
     !sel_light && !sel_halt && !sel_pllstop) |=> state == pwr_pkg::ST_RUN;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved");
  property p_resume_clear;
    @(posedge aclk) disable iff (!aresetn)
    (state == pwr_pkg::ST_RESUME && !sel_write) |=>
      sleep_select_field == `SEL_NONE;
  endproperty
  a_resume_clear: assert property (p_resume_clear) else $error("clr");
  property p_wake_pulse;
    @(posedge aclk) disable iff (!aresetn)
    wake.resume |=> !wake.resume;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("pulse");
  property p_no_isr;
    @(posedge aclk) disable iff (!aresetn)
    (wake.resume && !irq_enabled) |-> !wake.run_isr;
  endproperty
  a_no_isr: assert property (p_no_isr) else $error("isr");

endmodule

//--- tb/pwr_core_model.sv
`timescale 1ns/100ps
module pwr_core_model (
  // clock
  input  wire logic        aclk,
  // register bus master
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [3:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  // interrupt lines
  output logic             irq_pending,
  output logic             irq_enabled
);
  // idle bus and quiet interrupts at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_rready, irq_pending, irq_enabled} = '0;
  end

  // one word write, whole field at once with the spare top bit zero
  task automatic csr_write(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d & 32'hFFFF_7FFF;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // one word read, answer data and code returned
  task automatic csr_read(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) begin
      @(posedge aclk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // interrupt request levels
  task automatic set_irq(input logic p, input logic e);
    @(posedge aclk);
    irq_pending <= p;
    irq_enabled <= e;
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int LOCK = 4;
  logic aclk, aresetn, pll_cold_start, irq_pending, irq_enabled;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, io_freeze, sleep_indicator_pin;
  logic core_ready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, w;
  logic [5:0] code;
  logic [1:0] last_bresp;
  pwr_pkg::clk_ctrl_t clk_ctrl;
  pwr_pkg::wake_t wake;
  int fails, compares, cyc, seed, n;

  cpu_power_down_control #(.LOCK_CYCLES(LOCK)) cpu_power_down_control_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq_pending, .irq_enabled, .pll_cold_start, .clk_ctrl,
    .wake, .io_freeze, .sleep_indicator_pin, .core_ready);
  pwr_core_model pwr_core_model_inst (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_pending, .irq_enabled);

  // last write response code taken by the master
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) last_bresp <= s_axi_bresp;
  end

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic stop_test;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // clock enables expected for a field value
  function automatic logic [4:0] exp_clk(input logic [5:0] c);
    case (c)
      6'h09, 6'h11: return 5'h0F;
      6'h1A:        return 5'h01;
      6'h1C:        return 5'h00;
      default:      return 5'h1F;
    endcase
  endfunction

  task automatic do_reset(input logic c);
    @(posedge aclk);
    pll_cold_start <= c;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // write field and enables, count cycles until the cpu clock stops
  task automatic enter(input logic [5:0] c, input logic [1:0] en);
    pwr_core_model_inst.csr_write(4'h0, {16'h0000, c, 8'h00, en});
    n = 0;
    while (clk_ctrl.cpu_clk_en === 1'b1 && n < 20) begin
      @(posedge aclk);
      #1 n++;
    end
  endtask

  task automatic wait_wake;
    w = 2'b00;
    n = 0;
    while (w == 2'b00 && n < 40) begin
      @(posedge aclk);
      #1 w = wake;
      n++;
    end
  endtask

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      stop_test;
    end
  end

  initial begin
    {aresetn, pll_cold_start, fails, compares, cyc} = '0;
    seed = 53;
    do_reset(1'b0);
    repeat (3) @(posedge aclk);
    #1 chk({core_ready, clk_ctrl}, 6'h3F);
    pwr_core_model_inst.csr_read(4'h0, rd, rr);
    chk(rd, 32'h0000_0000);
    pwr_core_model_inst.csr_read(4'h8, rd, rr);
    chk(rr, 2'h2);
    chk(rd, 32'h0000_0000);
    pwr_core_model_inst.csr_read(4'h4, rd, rr);
    chk(rd, 32'h0000_009F);
    pwr_core_model_inst.csr_write(4'h8, 32'h0000_0000);
    #1 chk(last_bresp, 2'h2);
    // enabled-wake light sleep under every enable pair
    for (int en = 0; en < 4; en++) begin
      enter(6'h09, en[1:0]);
      chk(n >= 7 && n <= 8, 1);
      chk(clk_ctrl, exp_clk(6'h09));
      pwr_core_model_inst.set_irq(1'b1, 1'b0);
      repeat (12) @(posedge aclk);
      #1 chk(clk_ctrl.cpu_clk_en, 1'b0);
      pwr_core_model_inst.set_irq(1'b1, 1'b1);
      wait_wake;
      chk(w[1], en == 3);
      chk(w[0], 1'b1);
      pwr_core_model_inst.set_irq(1'b0, 1'b0);
    end
    // any-interrupt light sleep woken by an unenabled request
    enter(6'h11, 2'b11);
    chk(clk_ctrl, exp_clk(6'h11));
    chk(last_bresp, 2'h0);
    pwr_core_model_inst.set_irq(1'b1, 1'b0);
    wait_wake;
    chk(w, 2'b01);
    pwr_core_model_inst.set_irq(1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    #1 chk(clk_ctrl, 5'h1F);
    // random reserved codes keep running
    repeat (4) begin
      code = 6'($random(seed));
      code[5] = 1'b0;
      if (exp_clk(code) != 5'h1F || code == 6'h00) code = 6'h05;
      enter(code, 2'b00);
      chk({clk_ctrl, sleep_indicator_pin}, {5'h1F, 1'b0});
      pwr_core_model_inst.csr_read(4'h0, rd, rr);
      chk(rd[15:10], code);
    end
    // clock halt ignores interrupts, leaves on reset
    enter(6'h1A, 2'b11);
    chk({clk_ctrl, io_freeze, sleep_indicator_pin}, 7'h07);
    pwr_core_model_inst.csr_read(4'h4, rd, rr);
    chk(rd, 32'h0000_00E1);
    pwr_core_model_inst.csr_read(4'h0, rd, rr);
    chk(rd, 32'h0000_6803);
    pwr_core_model_inst.set_irq(1'b1, 1'b1);
    repeat (30) @(posedge aclk);
    #1 chk({clk_ctrl, sleep_indicator_pin}, 6'h03);
    pwr_core_model_inst.set_irq(1'b0, 1'b0);
    do_reset(1'b0);
    repeat (3) @(posedge aclk);
    #1 chk({core_ready, clk_ctrl, sleep_indicator_pin}, 7'h7E);
    // pll input stop, then relock wait after reset
    enter(6'h1C, 2'b00);
    chk({clk_ctrl, io_freeze, sleep_indicator_pin}, 7'h03);
    do_reset(1'b1);
    n = 0;
    while (core_ready !== 1'b1 && n < 50) begin
      @(posedge aclk);
      #1 n++;
    end
    chk(n >= LOCK && n <= LOCK + 2, 1);
    stop_test;
  end
endmodule
